// ===== verilog/cap_pkg.sv
// constants and types for current adc post-processing
package cap_pkg;

    // =========================================================
    // extended configuration register layout
    localparam int unsigned CFG_GROUND_SWITCH_PIN_BIT  = 7;
    localparam int unsigned CFG_ACC_LSB     = 5;
    localparam int unsigned CFG_CMP_LSB     = 3;
    localparam int unsigned CFG_ORNG_BIT    = 2;
    localparam int unsigned CFG_RSVD_BIT    = 1;
    localparam int unsigned CFG_RCNT_BIT    = 0;
    localparam logic [7:0]  CFG_RESET       = 8'h00;
    localparam logic [7:0]  CFG_WR_MASK     = 8'hFD;

    // =========================================================
    // reset values of the counters and accumulator
    localparam logic [31:0] ACC_RESET       = 32'h0000_0000;
    localparam logic [7:0]  THR_CNT_RESET   = 8'h00;
    localparam logic [7:0]  THR_CNT_MAX     = 8'hFF;
    localparam logic [15:0] RES_CNT_RESET   = 16'h0000;
    localparam logic [15:0] VT_RESET        = 16'h0000;

    // =========================================================
    // overrange persistence time at the 125 MHz core clock
    localparam int unsigned CLK_MHZ         = 125;
    localparam int unsigned ORNG_TIME_NS    = 125000;
    localparam int unsigned ORNG_CYCLES     =
        (ORNG_TIME_NS * CLK_MHZ + 999) / 1000;

    // =========================================================
    // mode encodings
    typedef enum logic [1:0] {
        CAP_ACC_OFF     = 2'b00,
        CAP_ACC_CLAMP   = 2'b01,
        CAP_ACC_SIGNED  = 2'b10,
        CAP_ACC_UNDEF   = 2'b11
    } cap_acc_mode_e;

    typedef enum logic [1:0] {
        CAP_CMP_OFF     = 2'b00,
        CAP_CMP_PLAIN   = 2'b01,
        CAP_CMP_CLEAR   = 2'b10,
        CAP_CMP_DECR    = 2'b11
    } cap_cmp_mode_e;

endpackage

// ===== verilog/cap_persist.sv
// persistence filter: flags a level held longer than a cycle count
`timescale 1ns/1ps

module cap_persist #(
    parameter int unsigned CYCLES = 16
) (
    // clock, reset, enable
    input  wire logic core_clk_i,
    input  wire logic srst_i,
    input  wire logic ce_i,
    // filter
    input  wire logic enable_i,
    input  wire logic level_i,
    output logic      hit_o
);

    localparam int unsigned W = $clog2(CYCLES + 2);
    localparam logic [W-1:0] LIMIT = W'(CYCLES);

    logic [W-1:0] count;
    logic [W-1:0] next_count;
    logic         next_hit;

    // =========================================================
    // count while continuously high; one pulse once past the limit
    always_comb begin
        next_count = count;
        next_hit   = 1'b0;
        if (!enable_i || !level_i) begin
            next_count = '0;
        end else if (count <= LIMIT) begin
            next_count = count + W'(1);
            next_hit   = (count == LIMIT);
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            count <= '0;
            hit_o <= 1'b0;
        end else if (ce_i) begin
            count <= next_count;
            hit_o <= next_hit;
        end
    end

endmodule

// ===== verilog/cap_core.sv
// current adc extended configuration and result post-processing
`timescale 1ns/1ps

module cap_core #(
    parameter int unsigned ORNG_CYCLES = cap_pkg::ORNG_CYCLES
) (
    // clock, reset, enable
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic        ce_i,
    // extended configuration register port
    input  wire logic        cfg_wr_i,
    input  wire logic [7:0]  cfg_wdata_i,
    output logic      [7:0]  cfg_rdata_o,
    // companion register values and write strobes
    input  wire logic [15:0] current_threshold_i,
    input  wire logic [7:0]  threshold_count_limit_i,
    input  wire logic [15:0] result_count_limit_i,
    input  wire logic        twos_comp_i,
    input  wire logic        ctl_wr_i,
    input  wire logic        mode_wr_i,
    // current conversion results
    input  wire logic        cur_ready_i,
    input  wire logic [15:0] cur_result_i,
    // voltage/temperature conversion results
    input  wire logic        vt_ready_i,
    input  wire logic [15:0] vt_result_i,
    // coarse overrange comparator, analog side
    input  wire logic        coarse_over_i,
    // status flag clears
    input  wire logic        cmp_clr_i,
    input  wire logic        orng_clr_i,
    // outputs
    output logic             ground_switch_pin_o,
    output logic      [31:0] accumulator_o,
    output logic      [7:0]  threshold_count_value_o,
    output logic      [15:0] result_count_value_o,
    output logic             cmp_flag_o,
    output logic             orng_flag_o,
    output logic             cur_irq_o,
    output logic      [15:0] vt_result_o
);

    // =========================================================
    // configuration register
    logic [7:0] cfg;
    logic [7:0] next_cfg;
    logic       ground_switch_pin;
    logic       next_ground_switch_pin;

    always_comb begin
        next_cfg    = cfg;
        if (cfg_wr_i) begin
            // reserved bit kept at zero whatever is written
            next_cfg = cfg_wdata_i & cap_pkg::CFG_WR_MASK;
        end
        next_ground_switch_pin = next_cfg[cap_pkg::CFG_GROUND_SWITCH_PIN_BIT];
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            cfg    <= cap_pkg::CFG_RESET;
            ground_switch_pin <= 1'b0;
        end else if (ce_i) begin
            cfg    <= next_cfg;
            ground_switch_pin <= next_ground_switch_pin;
        end
    end

    cap_pkg::cap_acc_mode_e acc_mode;
    cap_pkg::cap_cmp_mode_e cmp_mode;
    logic                   orng_en;
    logic                   rcnt_en;

    assign acc_mode = cap_pkg::cap_acc_mode_e'(
        cfg[cap_pkg::CFG_ACC_LSB +: 2]);
    assign cmp_mode = cap_pkg::cap_cmp_mode_e'(
        cfg[cap_pkg::CFG_CMP_LSB +: 2]);
    assign orng_en  = cfg[cap_pkg::CFG_ORNG_BIT];
    assign rcnt_en  = cfg[cap_pkg::CFG_RCNT_BIT];

    // =========================================================
    // sample shaping shared by accumulator and comparator
    logic [31:0] sample_ext;
    logic [15:0] magnitude;
    logic [15:0] thr_cmp;
    logic        at_or_above;

    always_comb begin
        if (twos_comp_i) begin
            sample_ext = {{16{cur_result_i[15]}}, cur_result_i};
            magnitude  = cur_result_i[15] ?
                         16'(~cur_result_i + 16'h0001) : cur_result_i;
            thr_cmp    = {1'b0, current_threshold_i[14:0]};
        end else begin
            sample_ext = {16'h0000, cur_result_i};
            magnitude  = cur_result_i;
            thr_cmp    = current_threshold_i;
        end
        at_or_above = (magnitude >= thr_cmp);
    end

    // =========================================================
    // accumulator
    logic [31:0] acc;
    logic [31:0] next_acc;
    logic [31:0] acc_sum;

    // plain 32-bit add: positive overflow wraps by design
    assign acc_sum = acc + sample_ext;

    always_comb begin
        next_acc = acc;
        unique case (acc_mode)
            cap_pkg::CAP_ACC_OFF: begin
                next_acc = cap_pkg::ACC_RESET;
            end
            cap_pkg::CAP_ACC_CLAMP: begin
                if (cur_ready_i) begin
                    // clamp only when a negative sample pulls below zero
                    if (sample_ext[31] && acc_sum[31]) begin
                        next_acc = cap_pkg::ACC_RESET;
                    end else begin
                        next_acc = acc_sum;
                    end
                end
            end
            cap_pkg::CAP_ACC_SIGNED: begin
                if (cur_ready_i) begin
                    next_acc = acc_sum;
                end
            end
            cap_pkg::CAP_ACC_UNDEF: begin
                next_acc = acc;
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            acc <= cap_pkg::ACC_RESET;
        end else if (ce_i) begin
            acc <= next_acc;
        end
    end

    // =========================================================
    // threshold comparator and counter
    logic [7:0] thr_cnt;
    logic [7:0] next_thr_cnt;
    logic       cmp_flag;
    logic       next_cmp_flag;
    logic       cmp_hit;

    always_comb begin
        next_thr_cnt = thr_cnt;
        cmp_hit      = 1'b0;
        unique case (cmp_mode)
            cap_pkg::CAP_CMP_OFF: begin
                next_thr_cnt = cap_pkg::THR_CNT_RESET;
            end
            cap_pkg::CAP_CMP_PLAIN: begin
                cmp_hit = cur_ready_i && at_or_above;
            end
            cap_pkg::CAP_CMP_CLEAR,
            cap_pkg::CAP_CMP_DECR: begin
                if (cur_ready_i) begin
                    if (at_or_above) begin
                        // saturate rather than wrap back through the limit
                        if (thr_cnt != cap_pkg::THR_CNT_MAX) begin
                            next_thr_cnt = thr_cnt + 8'h01;
                        end
                    end else if (cmp_mode == cap_pkg::CAP_CMP_CLEAR) begin
                        next_thr_cnt = cap_pkg::THR_CNT_RESET;
                    end else if (thr_cnt != cap_pkg::THR_CNT_RESET) begin
                        next_thr_cnt = thr_cnt - 8'h01;
                    end
                    cmp_hit = at_or_above &&
                        (next_thr_cnt == threshold_count_limit_i);
                end
            end
        endcase
        // set wins over a simultaneous clear
        next_cmp_flag = cmp_hit || (cmp_flag && !cmp_clr_i);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            thr_cnt  <= cap_pkg::THR_CNT_RESET;
            cmp_flag <= 1'b0;
        end else if (ce_i) begin
            thr_cnt  <= next_thr_cnt;
            cmp_flag <= next_cmp_flag;
        end
    end

    // =========================================================
    // result counter and current interrupt
    logic [15:0] res_cnt;
    logic [15:0] next_res_cnt;
    logic [15:0] res_inc;
    logic        cur_irq;
    logic        next_cur_irq;

    assign res_inc = res_cnt + 16'h0001;

    always_comb begin
        next_res_cnt = res_cnt;
        next_cur_irq = 1'b0;
        if (ctl_wr_i || mode_wr_i) begin
            next_res_cnt = cap_pkg::RES_CNT_RESET;
        end else if (cur_ready_i) begin
            if (!rcnt_en) begin
                next_cur_irq = 1'b1;
            end else if (res_inc == result_count_limit_i) begin
                next_cur_irq = 1'b1;
                next_res_cnt = cap_pkg::RES_CNT_RESET;
            end else begin
                next_res_cnt = res_inc;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            res_cnt <= cap_pkg::RES_CNT_RESET;
            cur_irq <= 1'b0;
        end else if (ce_i) begin
            res_cnt <= next_res_cnt;
            cur_irq <= next_cur_irq;
        end
    end

    // =========================================================
    // voltage/temperature latest result
    logic [15:0] vt_last;
    logic [15:0] next_vt_last;

    // intermediate results are simply overwritten, never queued
    always_comb begin
        next_vt_last = vt_ready_i ? vt_result_i : vt_last;
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            vt_last <= cap_pkg::VT_RESET;
        end else if (ce_i) begin
            vt_last <= next_vt_last;
        end
    end

    // =========================================================
    // overrange: synchronise the analog level, then filter
    logic over_meta;
    logic over_sync;
    logic orng_hit;
    logic orng_flag;
    logic next_orng_flag;

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            over_meta <= 1'b0;
            over_sync <= 1'b0;
        end else if (ce_i) begin
            over_meta <= coarse_over_i;
            over_sync <= over_meta;
        end
    end

    cap_persist #(
        .CYCLES     (ORNG_CYCLES)
    ) u_orng_filter (
        .core_clk_i (core_clk_i),
        .srst_i     (srst_i),
        .ce_i       (ce_i),
        .enable_i   (orng_en),
        .level_i    (over_sync),
        .hit_o      (orng_hit)
    );

    always_comb begin
        next_orng_flag = (orng_en && orng_hit) ||
                         (orng_flag && !orng_clr_i);
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            orng_flag <= 1'b0;
        end else if (ce_i) begin
            orng_flag <= next_orng_flag;
        end
    end

    // =========================================================
    // outputs, all straight from flip-flops
    assign cfg_rdata_o             = cfg;
    assign ground_switch_pin_o     = ground_switch_pin;
    assign accumulator_o           = acc;
    assign threshold_count_value_o = thr_cnt;
    assign result_count_value_o    = res_cnt;
    assign cmp_flag_o              = cmp_flag;
    assign orng_flag_o             = orng_flag;
    assign cur_irq_o               = cur_irq;
    assign vt_result_o             = vt_last;

endmodule

// ===== dv/cap_core_props.sv
// port-level assertion checker for the current adc post-processing core
`timescale 1ns/1ps

// ==========================================================
// checker
module cap_core_props #(
    parameter int unsigned ORNG_CYCLES = 20
) (
    // clock, reset, enable
    input wire logic        core_clk_i,
    input wire logic        srst_i,
    input wire logic        ce_i,
    // configuration and companion registers
    input wire logic        cfg_wr_i,
    input wire logic [7:0]  cfg_wdata_i,
    input wire logic [7:0]  cfg_rdata_o,
    input wire logic [15:0] current_threshold_i,
    input wire logic [15:0] result_count_limit_i,
    input wire logic        twos_comp_i,
    input wire logic        ctl_wr_i,
    input wire logic        mode_wr_i,
    // conversion and analog inputs
    input wire logic        cur_ready_i,
    input wire logic [15:0] cur_result_i,
    input wire logic        coarse_over_i,
    // outputs
    input wire logic        ground_switch_pin_o,
    input wire logic [31:0] accumulator_o,
    input wire logic [7:0]  threshold_count_value_o,
    input wire logic [15:0] result_count_value_o,
    input wire logic        cmp_flag_o,
    input wire logic        orng_flag_o,
    input wire logic        cur_irq_o
);
    logic [15:0] mag;
    logic [15:0] thr;
    logic [31:0] smp;
    logic        go;
    logic [15:0] hi_cnt;
    logic [15:0] next_hi_cnt;

    assign mag = (twos_comp_i && cur_result_i[15]) ? 16'h0000 - cur_result_i
                                                   : cur_result_i;
    assign thr = twos_comp_i ? {1'b0, current_threshold_i[14:0]}
                             : current_threshold_i;
    assign smp = {{16{twos_comp_i & cur_result_i[15]}}, cur_result_i};
    // a control or mode write drops the ready of that cycle
    assign go = ce_i && cur_ready_i && !ctl_wr_i && !mode_wr_i;

    // length of the current high episode of the raw analog level
    always_comb begin
        next_hi_cnt = hi_cnt;
        if (!coarse_over_i) begin
            next_hi_cnt = 16'h0000;
        end else if (ce_i && hi_cnt != 16'hFFFF) begin
            next_hi_cnt = hi_cnt + 16'h0001;
        end
    end
    always_ff @(posedge core_clk_i) begin
        hi_cnt <= srst_i ? 16'h0000 : next_hi_cnt;
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (srst_i);

    gnd_follow_a: assert property (ce_i && cfg_wr_i |=>
        ground_switch_pin_o == $past(cfg_wdata_i[7])) else $error("gnd pin");
    acc_off_a: assert property (ce_i && cfg_rdata_o[6:5] == 2'b00 |=>
        accumulator_o == 32'h0000_0000) else $error("acc not zero");
    acc_clamp_a: assert property (ce_i && cur_ready_i && smp[31] &&
        cfg_rdata_o[6:5] == 2'b01 |=> !accumulator_o[31])
        else $error("acc below zero");
    acc_signed_a: assert property (ce_i && cur_ready_i &&
        cfg_rdata_o[6:5] == 2'b10 |=>
        accumulator_o == $past(accumulator_o) + $past(smp))
        else $error("acc sum");
    cmp_off_a: assert property (ce_i && cfg_rdata_o[4:3] == 2'b00 |=>
        threshold_count_value_o == 8'h00 && !$rose(cmp_flag_o))
        else $error("cmp active");
    cmp_plain_a: assert property (ce_i && cur_ready_i && mag >= thr &&
        cfg_rdata_o[4:3] == 2'b01 |=> cmp_flag_o) else $error("cmp miss");
    irq_each_a: assert property (go && !cfg_rdata_o[0] |=> cur_irq_o)
        else $error("irq missing");
    irq_limit_a: assert property (go && cfg_rdata_o[0] &&
        result_count_value_o + 16'h0001 == result_count_limit_i |=>
        cur_irq_o && result_count_value_o == 16'h0000)
        else $error("count limit");
    cnt_clear_a: assert property (ce_i && (ctl_wr_i || mode_wr_i) |=>
        result_count_value_o == 16'h0000) else $error("count kept");
    irq_cause_a: assert property (cur_irq_o |-> $past(cur_ready_i))
        else $error("irq no ready");
    orng_persist_a: assert property ($rose(orng_flag_o) |->
        $past(hi_cnt, 3) > ORNG_CYCLES) else $error("orng early");
endmodule

bind cap_core cap_core_props #(.ORNG_CYCLES(ORNG_CYCLES)) u_props (
    .core_clk_i, .srst_i, .ce_i, .cfg_wr_i, .cfg_wdata_i, .cfg_rdata_o,
    .current_threshold_i, .result_count_limit_i, .twos_comp_i, .ctl_wr_i,
    .mode_wr_i, .cur_ready_i, .cur_result_i, .coarse_over_i,
    .ground_switch_pin_o, .accumulator_o, .threshold_count_value_o,
    .result_count_value_o, .cmp_flag_o, .orng_flag_o, .cur_irq_o
);

// ===== dv/cap_conv_model.sv
// behavioural converter result path feeding the core
`timescale 1ns/1ps

// ==========================================================
// converter model
module cap_conv_model (
    // clock
    input  wire logic        core_clk_i,
    // result path
    output logic             cur_ready_o,
    output logic      [15:0] cur_result_o,
    output logic             vt_ready_o,
    output logic      [15:0] vt_result_o
);
    initial begin
        cur_ready_o = 1'b0;
        cur_result_o = 16'h0000;
        vt_ready_o = 1'b0;
        vt_result_o = 16'h0000;
    end
    // stale bus shows the inverse so a late sample cannot match
    task automatic convert(input logic [15:0] v, input int gap);
        @(negedge core_clk_i);
        cur_ready_o = 1'b1;
        cur_result_o = v;
        @(negedge core_clk_i);
        cur_ready_o = 1'b0;
        cur_result_o = ~v;
        repeat (gap) @(negedge core_clk_i);
    endtask
    task automatic vt_convert(input logic [15:0] v);
        @(negedge core_clk_i);
        vt_ready_o = 1'b1;
        vt_result_o = v;
        @(negedge core_clk_i);
        vt_ready_o = 1'b0;
        vt_result_o = ~v;
    endtask
endmodule

// ===== dv/tb_top.sv
// self-checking bench for the current adc post-processing core
`timescale 1ns/1ps

// ==========================================================
// bench
module tb_top;
    logic        core_clk_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        cfg_wr_i = 1'b0;
    logic [7:0]  cfg_wdata_i = 8'h00;
    logic [15:0] thr = 16'h0010;
    logic [7:0]  tcl = 8'h03;
    logic [15:0] rcl = 16'h0003;
    logic        twos = 1'b0;
    logic        ctl_wr = 1'b0;
    logic        mode_wr = 1'b0;
    logic        over = 1'b0;
    logic        cmp_clr = 1'b0;
    logic        orng_clr = 1'b0;
    logic        ce = 1'b1;
    logic        crdy, vrdy, gnd, cmpf, orngf, irq;
    logic [15:0] cres, vres, rcv, vt_o;
    logic [7:0]  cfg_o, thv;
    logic [31:0] acc;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          cycles = 0;

    always #4 core_clk_i = ~core_clk_i;

    cap_conv_model u_conv (.core_clk_i(core_clk_i), .cur_ready_o(crdy),
        .cur_result_o(cres), .vt_ready_o(vrdy), .vt_result_o(vres));

    cap_core #(.ORNG_CYCLES(20)) uut (.core_clk_i(core_clk_i),
        .srst_i(srst_i), .ce_i(ce), .cfg_wr_i(cfg_wr_i),
        .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_o),
        .current_threshold_i(thr), .threshold_count_limit_i(tcl),
        .result_count_limit_i(rcl), .twos_comp_i(twos), .ctl_wr_i(ctl_wr),
        .mode_wr_i(mode_wr), .cur_ready_i(crdy), .cur_result_i(cres),
        .vt_ready_i(vrdy), .vt_result_i(vres), .coarse_over_i(over),
        .cmp_clr_i(cmp_clr), .orng_clr_i(orng_clr),
        .ground_switch_pin_o(gnd), .accumulator_o(acc),
        .threshold_count_value_o(thv), .result_count_value_o(rcv),
        .cmp_flag_o(cmpf), .orng_flag_o(orngf), .cur_irq_o(irq),
        .vt_result_o(vt_o));

    task automatic summarize();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask

    task automatic wr_cfg(input logic [7:0] v);
        @(negedge core_clk_i);
        cfg_wr_i = 1'b1;
        cfg_wdata_i = v;
        @(negedge core_clk_i);
        cfg_wr_i = 1'b0;
    endtask

    task automatic t_cfg();
        chk(cfg_o, 8'h00);
        wr_cfg(8'hA1);
        chk(cfg_o, 8'hA1);
        chk(gnd, 1'b1);
        wr_cfg(8'h00);
        chk(gnd, 1'b0);
    endtask

    task automatic t_acc();
        twos = 1'b1;
        wr_cfg(8'h20);
        u_conv.convert(16'h0005, 0);
        u_conv.convert(16'hFFF8, 0);
        chk(acc, 32'h0000_0000);
        u_conv.convert(16'h0003, 2);
        chk(acc, 32'h0000_0003);
        wr_cfg(8'h00);
        @(negedge core_clk_i);
        chk(acc, 32'h0000_0000);
        // off for two ready events before re-enabling
        u_conv.convert(16'h0007, 0);
        u_conv.convert(16'h0007, 0);
        chk(acc, 32'h0000_0000);
        wr_cfg(8'h40);
        u_conv.convert(16'h0002, 0);
        u_conv.convert(16'hFFFB, 0);
        chk(acc, 32'hFFFF_FFFD);
        twos = 1'b0;
    endtask

    task automatic t_cmp();
        wr_cfg(8'h10);
        u_conv.convert(16'h0010, 0);
        u_conv.convert(16'h0020, 0);
        chk(thv, 8'h02);
        u_conv.convert(16'h000F, 0);
        chk(thv, 8'h00);
        for (int i = 0; i < 3; i++) begin
            chk(cmpf, 1'b0);
            u_conv.convert(16'h0011, 0);
        end
        chk(cmpf, 1'b1);
        wr_cfg(8'h00);
        cmp_clr = 1'b1;
        @(negedge core_clk_i);
        cmp_clr = 1'b0;
        chk(thv, 8'h00);
        chk(cmpf, 1'b0);
        wr_cfg(8'h18);
        u_conv.convert(16'h0010, 0);
        u_conv.convert(16'h0010, 0);
        u_conv.convert(16'h0001, 0);
        chk(thv, 8'h01);
        u_conv.convert(16'h0010, 0);
        u_conv.convert(16'h0010, 0);
        chk(cmpf, 1'b1);
        wr_cfg(8'h08);
        cmp_clr = 1'b1;
        twos = 1'b1;
        thr = 16'h8010;
        @(negedge core_clk_i);
        cmp_clr = 1'b0;
        u_conv.convert(16'hFFF1, 0);
        chk(cmpf, 1'b0);
        u_conv.convert(16'hFFF0, 0);
        chk(cmpf, 1'b1);
        twos = 1'b0;
    endtask

    task automatic t_rcnt();
        wr_cfg(8'h00);
        u_conv.convert(16'h0001, 0);
        chk(irq, 1'b1);
        wr_cfg(8'h01);
        for (int i = 1; i < 3; i++) begin
            u_conv.convert(16'h0001, 0);
            chk({irq, rcv}, {1'b0, 16'(i)});
        end
        u_conv.convert(16'h0001, 0);
        chk({irq, rcv}, {1'b1, 16'h0000});
        u_conv.convert(16'h0001, 1);
        ctl_wr = 1'b1;
        @(negedge core_clk_i);
        ctl_wr = 1'b0;
        chk(rcv, 16'h0000);
        u_conv.convert(16'h0001, 0);
        mode_wr = 1'b1;
        @(negedge core_clk_i);
        mode_wr = 1'b0;
        chk(rcv, 16'h0000);
    endtask

    task automatic t_orng();
        wr_cfg(8'h04);
        over = 1'b1;
        repeat (10) @(negedge core_clk_i);
        over = 1'b0;
        repeat (4) @(negedge core_clk_i);
        chk(orngf, 1'b0);
        over = 1'b1;
        repeat (30) @(negedge core_clk_i);
        chk(orngf, 1'b1);
        wr_cfg(8'h00);
        orng_clr = 1'b1;
        @(negedge core_clk_i);
        orng_clr = 1'b0;
        repeat (30) @(negedge core_clk_i);
        chk(orngf, 1'b0);
        over = 1'b0;
    endtask

    // clock enable low must freeze every register; then undefined mode holds
    task automatic t_ce();
        wr_cfg(8'h40);
        u_conv.convert(16'h0004, 1);
        ce = 1'b0;
        u_conv.convert(16'h0004, 0);
        wr_cfg(8'h00);
        chk(acc, 32'h0000_0004);
        chk(cfg_o, 8'h40);
        ce = 1'b1;
        u_conv.convert(16'h0004, 0);
        chk(acc, 32'h0000_0008);
        wr_cfg(8'h60);
        u_conv.convert(16'h0004, 0);
        chk(acc, 32'h0000_0008);
    endtask

    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        repeat (3) @(negedge core_clk_i);
        srst_i = 1'b0;
        t_cfg();
        t_acc();
        t_cmp();
        t_rcnt();
        t_orng();
        t_ce();
        u_conv.vt_convert(16'h1111);
        u_conv.vt_convert(16'h1234);
        chk(vt_o, 16'h1234);
        summarize();
    end
endmodule
